// *** shared/dmx_consts.svh ***
// constants of the data-move execution block: phases, encodings, map, resets
// assumes inclusion by bare name from the design modules and the bench
`ifndef DMX_CONSTS_SVH
`define DMX_CONSTS_SVH

// ----------------------------------------------------------------
// phases of one instruction cycle
// ----------------------------------------------------------------
`define DMX_PH_Q1 2'h0
`define DMX_PH_Q2 2'h1
`define DMX_PH_Q3 2'h2
`define DMX_PH_Q4 2'h3

// ----------------------------------------------------------------
// instruction encodings
// ----------------------------------------------------------------
`define DMX_ENC_MOVE 6'h14
`define DMX_ENC_COPY 4'hC
`define DMX_ENC_WORD2 4'hF
`define DMX_ENC_BANK 8'h01
`define DMX_ENC_PTR 10'h3B8
`define DMX_BIT_DEST 9
`define DMX_BIT_ACC 8

// ----------------------------------------------------------------
// data space
// ----------------------------------------------------------------
`define DMX_ACC_SPLIT 8'h60
`define DMX_IDX_LIMIT 8'h5F
`define DMX_ACC_HI_BANK 4'hF
`define DMX_WREG_ADDR 12'hFFF
`define DMX_IDX_PTR 2
`define DMX_PTR_COUNT 3

// ----------------------------------------------------------------
// register map, byte offsets
// ----------------------------------------------------------------
`define DMX_OFF_CTRL 8'h00
`define DMX_OFF_BANK 8'h04
`define DMX_OFF_PTR0 8'h08
`define DMX_OFF_PTR1 8'h0C
`define DMX_OFF_PTR2 8'h10
`define DMX_OFF_WREG 8'h14
`define DMX_OFF_STAT 8'h18
`define DMX_CTRL_EXT 0
`define DMX_RESP_OKAY 2'h0
`define DMX_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DMX_RST_BANK 4'h0
`define DMX_RST_W 8'h00
`define DMX_RST_PTR 12'h000
`define DMX_RST_EXT 1'h0

`endif

// *** shared/dmx_pkg.sv ***
// types of the data-move execution block
// assumes the constants header sits beside it
package dmx_pkg;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_MOVE = 3'b001,
		OP_COPY1 = 3'b010,
		OP_COPY2 = 3'b011,
		OP_PTR1 = 3'b100,
		OP_PTR2 = 3'b101,
		OP_BANK = 3'b110
	} dmx_op_t;

	typedef struct packed {
		logic aw_held;
		logic [7:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} dmx_axil_t;

	typedef struct packed {
		logic [1:0] phase;
		logic act;
		dmx_op_t op;
		logic [11:0] addr;
		logic self_w;
		logic dest;
		logic [7:0] data;
		logic [1:0] ptr_sel;
		logic [3:0] lit_hi;
		logic [7:0] lit;
		logic dm_rd;
		logic dm_wr;
		logic [11:0] dm_addr;
		logic [7:0] dm_wdata;
		logic [7:0] w;
		logic [3:0] bank;
		logic [2:0][11:0] ptr;
		logic ext_en;
		logic flag_n;
		logic flag_z;
	} dmx_core_t;

endpackage : dmx_pkg

// *** logic/dmx_addr_gen.sv ***
// banked address formation for the single-word file instructions
// assumes the bank and the index pointer come from flip-flops of the caller
`timescale 1ns/100ps
`include "dmx_consts.svh"

module dmx_addr_gen
(
	// instruction fields
	input wire logic [7:0] f,
	input wire logic acc_b,
	// core state
	input wire logic ext_en,
	input wire logic [3:0] bank,
	input wire logic [11:0] idx_ptr,
	// result
	output logic [11:0] addr,
	output logic indexed
);

	always_comb
	begin
		indexed = !acc_b && ext_en && (f <= `DMX_IDX_LIMIT);
		if (indexed)
			addr = idx_ptr + {4'h0, f};
		else if (acc_b)
			addr = {bank, f};
		else if (f < `DMX_ACC_SPLIT)
			addr = {4'h0, f};
		else
			addr = {`DMX_ACC_HI_BANK, f};
	end

endmodule : dmx_addr_gen

// *** logic/dmx_axil_slave.sv ***
// AXI4-Lite slave front end: one write and one read at a time
// assumes the owner decodes addresses and supplies read data combinationally
`timescale 1ns/100ps
`include "dmx_consts.svh"

module dmx_axil_slave
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// write channels
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read channels
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register side
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);

	dmx_pkg::dmx_axil_t r_reg;
	dmx_pkg::dmx_axil_t r_next;

	assign awready = !r_reg.aw_held;
	assign wready = !r_reg.w_held;
	assign arready = !r_reg.rvalid;
	assign bvalid = r_reg.bvalid;
	assign bresp = r_reg.bresp;
	assign rvalid = r_reg.rvalid;
	assign rdata = r_reg.rdata;
	assign rresp = r_reg.rresp;
	assign wr_addr = r_reg.awaddr;
	assign wr_data = r_reg.wdata;
	assign wr_strb = r_reg.wstrb;
	assign rd_addr = araddr;

	always_comb
	begin
		r_next = r_reg;
		wr_en = 1'b0;
		if (r_reg.bvalid && bready)
			r_next.bvalid = 1'b0;
		if (awvalid && !r_reg.aw_held)
		begin
			r_next.aw_held = 1'b1;
			r_next.awaddr = awaddr;
		end
		if (wvalid && !r_reg.w_held)
		begin
			r_next.w_held = 1'b1;
			r_next.wdata = wdata;
			r_next.wstrb = wstrb;
		end
		// the write waits for both halves and for the previous response to drain
		if (r_reg.aw_held && r_reg.w_held && !r_reg.bvalid)
		begin
			wr_en = 1'b1;
			r_next.aw_held = 1'b0;
			r_next.w_held = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = wr_ok ? `DMX_RESP_OKAY : `DMX_RESP_SLVERR;
		end
		if (r_reg.rvalid && rready)
			r_next.rvalid = 1'b0;
		if (arvalid && !r_reg.rvalid)
		begin
			r_next.rvalid = 1'b1;
			r_next.rdata = rd_ok ? rd_data : 32'h00000000;
			r_next.rresp = rd_ok ? `DMX_RESP_OKAY : `DMX_RESP_SLVERR;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

endmodule : dmx_axil_slave

// *** logic/dmx_exec_top.sv ***
// execution of the pointer-load, file-move, register copy and bank-literal
// instructions, with four clock phases per instruction cycle
// assumes program memory offers words at phase Q1 and data memory answers a
// read one clock after DM_RD, writing at the clock edge that ends DM_WR
`timescale 1ns/100ps
`include "dmx_consts.svh"

module dmx_exec_top
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_B,
	// instruction words
	input wire logic [15:0] INSTR_WORD,
	input wire logic INSTR_VALID,
	output logic INSTR_READY,
	// data memory port
	output logic [11:0] DM_ADDR,
	output logic DM_RD,
	input wire logic [7:0] DM_RDATA,
	output logic DM_WR,
	output logic [7:0] DM_WDATA,
	// status flags
	output logic FLAG_N,
	output logic FLAG_Z,
	// register bus
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);

	dmx_pkg::dmx_core_t r;
	dmx_pkg::dmx_core_t n;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;
	logic [11:0] bank_addr;
	logic [7:0] src_byte;

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	dmx_axil_slave u_bus
	(
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.awaddr(S_AXI_AWADDR),
		.awvalid(S_AXI_AWVALID),
		.awready(S_AXI_AWREADY),
		.wdata(S_AXI_WDATA),
		.wstrb(S_AXI_WSTRB),
		.wvalid(S_AXI_WVALID),
		.wready(S_AXI_WREADY),
		.bresp(S_AXI_BRESP),
		.bvalid(S_AXI_BVALID),
		.bready(S_AXI_BREADY),
		.araddr(S_AXI_ARADDR),
		.arvalid(S_AXI_ARVALID),
		.arready(S_AXI_ARREADY),
		.rdata(S_AXI_RDATA),
		.rresp(S_AXI_RRESP),
		.rvalid(S_AXI_RVALID),
		.rready(S_AXI_RREADY),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	// read-only registers accept writes silently; only holes answer with an error
	always_comb
	begin
		rd_ok = 1'b1;
		case (rd_addr)
			`DMX_OFF_CTRL: rd_data = {31'h00000000, r.ext_en};
			`DMX_OFF_BANK: rd_data = {28'h0000000, r.bank};
			`DMX_OFF_PTR0: rd_data = {20'h00000, r.ptr[0]};
			`DMX_OFF_PTR1: rd_data = {20'h00000, r.ptr[1]};
			`DMX_OFF_PTR2: rd_data = {20'h00000, r.ptr[2]};
			`DMX_OFF_WREG: rd_data = {24'h000000, r.w};
			`DMX_OFF_STAT: rd_data = {24'h000000, r.flag_z, r.flag_n, r.op, r.act, r.phase};
			default:
			begin
				rd_data = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
		wr_ok = (wr_addr <= `DMX_OFF_STAT) && (wr_addr[1:0] == 2'h0);
	end

	// ----------------------------------------------------------------
	// address formation
	// ----------------------------------------------------------------
	dmx_addr_gen u_agen
	(
		.f(INSTR_WORD[7:0]),
		.acc_b(INSTR_WORD[`DMX_BIT_ACC]),
		.ext_en(r.ext_en),
		.bank(r.bank),
		.idx_ptr(r.ptr[`DMX_IDX_PTR]),
		.addr(bank_addr),
		.indexed()
	);

	assign INSTR_READY = (r.phase == `DMX_PH_Q1);
	assign DM_ADDR = r.dm_addr;
	assign DM_RD = r.dm_rd;
	assign DM_WR = r.dm_wr;
	assign DM_WDATA = r.dm_wdata;
	assign FLAG_N = r.flag_n;
	assign FLAG_Z = r.flag_z;
	// W is held here, so a read of its data address never goes to memory
	assign src_byte = r.self_w ? r.w : DM_RDATA;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_comb
	begin
		n = r;
		n.phase = r.phase + 2'h1;
		if (wr_en && (wr_addr == `DMX_OFF_CTRL) && wr_strb[0])
			n.ext_en = wr_data[`DMX_CTRL_EXT];
		case (r.phase)
			`DMX_PH_Q1:
			begin
				n.act = INSTR_VALID;
				if (INSTR_VALID)
				begin
					n.op = dmx_pkg::OP_NONE;
					if (r.op == dmx_pkg::OP_COPY1)
					begin
						// a foreign second word cancels the copy and is dropped
						if (INSTR_WORD[15:12] == `DMX_ENC_WORD2)
						begin
							n.op = dmx_pkg::OP_COPY2;
							n.addr = INSTR_WORD[11:0];
							n.self_w = (INSTR_WORD[11:0] == `DMX_WREG_ADDR);
						end
					end
					else if (r.op == dmx_pkg::OP_PTR1)
					begin
						if (INSTR_WORD[15:12] == `DMX_ENC_WORD2)
						begin
							n.op = dmx_pkg::OP_PTR2;
							n.lit = INSTR_WORD[7:0];
						end
					end
					else if (INSTR_WORD[15:10] == `DMX_ENC_MOVE)
					begin
						n.op = dmx_pkg::OP_MOVE;
						n.addr = bank_addr;
						n.dest = INSTR_WORD[`DMX_BIT_DEST];
						n.self_w = (bank_addr == `DMX_WREG_ADDR);
					end
					else if (INSTR_WORD[15:12] == `DMX_ENC_COPY)
					begin
						n.op = dmx_pkg::OP_COPY1;
						n.addr = INSTR_WORD[11:0];
						n.self_w = (INSTR_WORD[11:0] == `DMX_WREG_ADDR);
					end
					else if (INSTR_WORD[15:6] == `DMX_ENC_PTR)
					begin
						n.op = dmx_pkg::OP_PTR1;
						n.ptr_sel = INSTR_WORD[5:4];
						n.lit_hi = INSTR_WORD[3:0];
					end
					else if (INSTR_WORD[15:8] == `DMX_ENC_BANK)
					begin
						n.op = dmx_pkg::OP_BANK;
						n.lit = INSTR_WORD[7:0];
					end
					// reads are issued only for the first cycle of a move or copy
					if ((n.op == dmx_pkg::OP_MOVE || n.op == dmx_pkg::OP_COPY1) && !n.self_w)
					begin
						n.dm_rd = 1'b1;
						n.dm_addr = n.addr;
					end
				end
			end
			`DMX_PH_Q2:
				n.dm_rd = 1'b0;
			`DMX_PH_Q3:
			begin
				if (r.act && (r.op == dmx_pkg::OP_MOVE || r.op == dmx_pkg::OP_COPY1))
					n.data = src_byte;
				if (r.act && r.op == dmx_pkg::OP_MOVE && r.dest && !r.self_w)
				begin
					n.dm_wr = 1'b1;
					n.dm_addr = r.addr;
					n.dm_wdata = DM_RDATA;
				end
				if (r.act && r.op == dmx_pkg::OP_COPY2 && !r.self_w)
				begin
					n.dm_wr = 1'b1;
					n.dm_addr = r.addr;
					n.dm_wdata = r.data;
				end
			end
			`DMX_PH_Q4:
			begin
				n.dm_wr = 1'b0;
				if (r.act)
				begin
					case (r.op)
						dmx_pkg::OP_MOVE:
						begin
							if (!r.dest || r.self_w)
								n.w = r.data;
							n.flag_n = r.data[7];
							n.flag_z = (r.data == 8'h00);
						end
						dmx_pkg::OP_COPY2:
							if (r.self_w)
								n.w = r.data;
						dmx_pkg::OP_PTR1:
							if (r.ptr_sel < `DMX_PTR_COUNT)
								n.ptr[r.ptr_sel][11:8] = r.lit_hi;
						dmx_pkg::OP_PTR2:
							if (r.ptr_sel < `DMX_PTR_COUNT)
								n.ptr[r.ptr_sel][7:0] = r.lit;
						dmx_pkg::OP_BANK:
							n.bank = r.lit[3:0];
						default:
							n.w = r.w;
					endcase
				end
			end
			default:
				n.phase = `DMX_PH_Q1;
		endcase
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_B)
		begin
			r <= '0;
			r.w <= `DMX_RST_W;
			r.bank <= `DMX_RST_BANK;
			r.ptr <= {`DMX_PTR_COUNT{`DMX_RST_PTR}};
			r.ext_en <= `DMX_RST_EXT;
		end
		else
			r <= n;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);

	sequence s_q2_quiet;
		!DM_RD && !DM_WR;
	endsequence

	sequence s_q4_write(logic [7:0] d);
		DM_WR && DM_WDATA == d;
	endsequence

	chk_ptr_low_load: assert property (
		(r.act && r.op == dmx_pkg::OP_PTR2 && r.phase == `DMX_PH_Q4 && r.ptr_sel == 2'h1)
		|=> r.ptr[1][7:0] == $past(r.lit) && r.ptr[1][11:8] == $past(r.ptr[1][11:8]))
		else $error("pointer low byte not loaded");
	chk_move_to_w: assert property (
		(r.act && r.op == dmx_pkg::OP_MOVE && !r.dest && r.phase == `DMX_PH_Q3)
		|=> !DM_WR ##1 r.w == $past(r.data))
		else $error("file move to W failed");
	chk_move_back: assert property (
		(r.act && r.op == dmx_pkg::OP_MOVE && r.dest && !r.self_w && r.phase == `DMX_PH_Q3)
		|=> DM_WR && DM_ADDR == $past(r.addr) && DM_WDATA == $past(DM_RDATA))
		else $error("file move write-back wrong");
	chk_bank_addr: assert property (
		(r.phase == `DMX_PH_Q1 && INSTR_VALID
		&& r.op != dmx_pkg::OP_COPY1 && r.op != dmx_pkg::OP_PTR1
		&& INSTR_WORD[15:10] == `DMX_ENC_MOVE && INSTR_WORD[`DMX_BIT_ACC])
		|=> DM_RD && DM_ADDR == {$past(r.bank), $past(INSTR_WORD[7:0])} || r.self_w)
		else $error("banked address wrong");
	chk_indexed_addr: assert property (
		(r.phase == `DMX_PH_Q1 && INSTR_VALID && r.ext_en
		&& r.op != dmx_pkg::OP_COPY1 && r.op != dmx_pkg::OP_PTR1
		&& INSTR_WORD[15:10] == `DMX_ENC_MOVE && !INSTR_WORD[`DMX_BIT_ACC]
		&& INSTR_WORD[7:0] <= `DMX_IDX_LIMIT)
		|=> r.addr == $past(r.ptr[2]) + {4'h0, $past(INSTR_WORD[7:0])})
		else $error("indexed address wrong");
	chk_copy_read: assert property (
		(r.phase == `DMX_PH_Q1 && INSTR_VALID
		&& r.op != dmx_pkg::OP_COPY1 && r.op != dmx_pkg::OP_PTR1
		&& INSTR_WORD[15:12] == `DMX_ENC_COPY && INSTR_WORD[11:0] != `DMX_WREG_ADDR)
		|=> DM_RD && DM_ADDR == $past(INSTR_WORD[11:0]) && r.op == dmx_pkg::OP_COPY1)
		else $error("copy source read wrong");
	chk_copy_write: assert property (
		(r.act && r.op == dmx_pkg::OP_COPY2 && !r.self_w && r.phase == `DMX_PH_Q2)
		|-> s_q2_quiet ##2 s_q4_write(r.data))
		else $error("copy second cycle wrong");
	chk_copy_to_w: assert property (
		(r.act && r.op == dmx_pkg::OP_COPY2 && r.self_w && r.phase == `DMX_PH_Q4)
		|=> r.w == $past(r.data) && !DM_WR)
		else $error("copy into W failed");
	chk_bank_load: assert property (
		(r.act && r.op == dmx_pkg::OP_BANK && r.phase == `DMX_PH_Q4)
		|=> r.bank == $past(r.lit[3:0]))
		else $error("bank select not loaded");

endmodule : dmx_exec_top

// *** sim/dmx_exec_top_tb_top.sv ***
// self-checking bench of the data-move execution block
// assumes the design files and the constants header are compiled first
`timescale 1ns/100ps
`include "dmx_consts.svh"

module dmx_exec_top_tb_top;
	logic CORE_CLK = 1'b0;
	logic RST_B = 1'b0;
	logic [15:0] INSTR_WORD = 16'h0000;
	logic INSTR_VALID = 1'b0;
	logic [7:0] DM_RDATA = 8'h00;
	logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0;
	logic [3:0] S_AXI_WSTRB = 4'h0;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
	logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
	logic INSTR_READY, DM_RD, DM_WR, FLAG_N, FLAG_Z;
	logic [11:0] DM_ADDR;
	logic [7:0] DM_WDATA;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic [31:0] S_AXI_RDATA;
	int seed = 32'h0625;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [7:0] mem [4096];
	logic [19:0] wq [$];
	logic [33:0] xq [$];
	logic [11:0] pv [3];
	logic [11:0] s, t, ad;
	logic [7:0] k, f, wv;
	logic [3:0] bk;
	logic ext, a, d;

	always #50 CORE_CLK = ~CORE_CLK;

	dmx_exec_top DUT (.CORE_CLK, .RST_B, .INSTR_WORD, .INSTR_VALID, .INSTR_READY,
		.DM_ADDR, .DM_RD, .DM_RDATA, .DM_WR, .DM_WDATA, .FLAG_N, .FLAG_Z,
		.S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
		.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
		.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
		.S_AXI_RVALID, .S_AXI_RREADY);

	// ----------------------------------------------------------------
	// checking and drivers
	// ----------------------------------------------------------------
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	// waits one edge first so that no input is assigned twice in one time step
	task automatic ins(input logic [15:0] w, input logic v);
		@(posedge CORE_CLK);
		INSTR_WORD <= w;
		INSTR_VALID <= v;
		do @(posedge CORE_CLK); while (INSTR_READY !== 1'b1);
		@(posedge CORE_CLK);
		INSTR_VALID <= 1'b0;
		INSTR_WORD <= 16'($random(seed));
	endtask : ins

	task automatic axw(input logic [7:0] ad_w, input logic [31:0] dw, input logic [3:0] sw);
		logic aw_p, w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		xq.push_back({`DMX_RESP_OKAY, 32'h0});
		@(posedge CORE_CLK);
		S_AXI_AWADDR <= ad_w;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WDATA <= dw;
		S_AXI_WSTRB <= sw;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		while (aw_p || w_p)
		begin
			@(posedge CORE_CLK);
			if (aw_p && S_AXI_AWREADY === 1'b1)
			begin
				aw_p = 1'b0;
				S_AXI_AWVALID <= 1'b0;
			end
			if (w_p && S_AXI_WREADY === 1'b1)
			begin
				w_p = 1'b0;
				S_AXI_WVALID <= 1'b0;
			end
		end
		do @(posedge CORE_CLK); while (S_AXI_BVALID !== 1'b1);
		S_AXI_BREADY <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] ad_r, input logic [33:0] e);
		xq.push_back(e);
		@(posedge CORE_CLK);
		S_AXI_ARADDR <= ad_r;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do @(posedge CORE_CLK); while (S_AXI_ARREADY !== 1'b1);
		S_AXI_ARVALID <= 1'b0;
		do @(posedge CORE_CLK); while (S_AXI_RVALID !== 1'b1);
		S_AXI_RREADY <= 1'b0;
	endtask : axr

	// expected data address of a file move
	function automatic logic [11:0] ea(input logic ab, input logic [7:0] fa);
		if (ab)
			return {bk, fa};
		if (ext && fa <= 8'h5F)
			return pv[2] + {4'h0, fa};
		return (fa < 8'h60) ? {4'h0, fa} : {4'hF, fa};
	endfunction : ea

	// ----------------------------------------------------------------
	// data memory and result watcher
	// ----------------------------------------------------------------
	always @(posedge CORE_CLK)
	begin
		cyc++;
		// a released read bus shows noise, never the last value
		DM_RDATA <= (DM_RD === 1'b1) ? mem[DM_ADDR] : 8'($random(seed));
		if (DM_WR === 1'b1)
		begin
			mem[DM_ADDR] <= DM_WDATA;
			chk({14'h0, DM_ADDR, DM_WDATA}, wq.size() ? {14'h0, wq.pop_front()} : '1);
		end
		if (S_AXI_BVALID === 1'b1 && S_AXI_BREADY === 1'b1)
			chk({S_AXI_BRESP, 32'h0}, xq.pop_front() & {2'h3, 32'h0});
		if (S_AXI_RVALID === 1'b1 && S_AXI_RREADY === 1'b1)
			chk({S_AXI_RRESP, S_AXI_RDATA}, xq.pop_front());
		if (cyc == 20000)
		begin
			fails++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		for (int i = 0; i < 4096; i++)
			mem[i] = 8'($random(seed));
		pv = '{12'h0, 12'h0, 12'h0};
		bk = 4'h0;
		wv = 8'h00;
		ext = 1'b0;
		repeat (2) @(posedge CORE_CLK);
		RST_B <= 1'b1;
		axr(`DMX_OFF_CTRL, 34'h0);
		for (int i = 0; i < 5; i++)
			axr(8'h04 + 8'(4 * i), 34'h0);
		axr(8'h1C, {`DMX_RESP_SLVERR, 32'h0});
		axw(`DMX_OFF_BANK, 32'hF, 4'hF);
		axr(`DMX_OFF_BANK, 34'h0);
		$display("done: reset and bus");
		for (int i = 0; i < 4; i++)
		begin
			k = (i == 0) ? 8'hFF : 8'($random(seed));
			ins({8'h01, k}, 1'b1);
			bk = k[3:0];
			repeat (4) @(posedge CORE_CLK);
			axr(`DMX_OFF_BANK, {30'h0, bk});
		end
		$display("done: bank literal");
		for (int i = 0; i < 3; i++)
		begin
			// pointer 2 kept low so indexed addresses stay clear of W
			t = 12'($random(seed)) & ((i == 2) ? 12'h7FF : 12'hFFF);
			pv[i] = t;
			ins({10'h3B8, 2'(i), t[11:8]}, 1'b1);
			ins({8'hF0, t[7:0]}, 1'b1);
		end
		repeat (4) @(posedge CORE_CLK);
		for (int i = 0; i < 3; i++)
			axr(8'h08 + 8'(4 * i), {22'h0, pv[i]});
		$display("done: pointer load");
		for (int i = 0; i < 16; i++)
		begin
			if (i == 8)
			begin
				axw(`DMX_OFF_CTRL, 32'h1, 4'h1);
				ext = 1'b1;
			end
			k = 8'($random(seed));
			ins({8'h01, k}, 1'b1);
			bk = k[3:0];
			a = (i % 4 < 2) ? 1'b0 : 1'($random(seed));
			d = 1'($random(seed));
			f = (i % 4 < 2) ? 8'h5F + 8'(i % 2) : 8'({$random(seed)} % 255);
			ad = ea(a, f);
			k = mem[ad];
			if (d)
				wq.push_back({ad, k});
			ins({6'h14, d, a, f}, 1'b1);
			repeat (4) @(posedge CORE_CLK);
			chk({FLAG_N, FLAG_Z}, {k[7], k == 8'h00});
			if (!d)
			begin
				wv = k;
				axr(`DMX_OFF_WREG, {26'h0, wv});
			end
		end
		$display("done: file move");
		for (int i = 0; i < 6; i++)
		begin
			s = (i == 0) ? 12'hFFF : 12'({$random(seed)} % 4095);
			// special registers sit in the top page, so destinations stay below it
			t = 12'({$random(seed)} % 3840);
			if (i != 2)
				wq.push_back({t, (i == 0) ? wv : mem[s]});
			ins({4'hC, s}, 1'b1);
			if (i == 1)
				ins(16'h0000, 1'b0);
			ins((i == 2) ? 16'h0ABC : {4'hF, t}, 1'b1);
			repeat (4) @(posedge CORE_CLK);
		end
		$display("done: register copy");
		repeat (8) @(posedge CORE_CLK);
		chk(34'(wq.size() + xq.size()), 34'h0);
		final_report();
	end
endmodule : dmx_exec_top_tb_top
